// [logic/core_op_pkg.sv]
package core_op_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int DATA_W  = 8;
    localparam int FADDR_W = 7;
    localparam int PC_W    = 15;
    localparam int PCL_W   = 8;
    localparam int PCH_W   = 7;

    // ------------------------------------------------------------
    // Reset values and constants
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0]  ACCUM_RST  = 8'h00;
    localparam logic [DATA_W-1:0]  ZERO_BYTE  = 8'h00;
    localparam logic [DATA_W-1:0]  DEC_STEP   = 8'h01;
    localparam logic [PC_W-1:0]    PC_STEP    = 15'h0001;
    localparam logic [FADDR_W-1:0] FADDR_RST  = 7'h00;
    localparam logic [PC_W-1:0]    PC_RST     = 15'h0000;
    localparam logic               NIL_RST    = 1'b0;
    localparam logic               FLAG_N_RST = 1'b1;
    localparam logic               DEST_ACCUM = 1'b0;
    localparam logic               DEST_FILE  = 1'b1;

    // ------------------------------------------------------------
    // Operations and carriers
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        op_idle,
        op_call_via_accum,
        op_zero_file,
        op_zero_accum,
        op_kick,
        op_invert_file,
        op_minus_one,
        op_minus_one_skip
    } op_t;

    typedef struct packed {
        op_t                op;
        logic [FADDR_W-1:0] faddr;
        logic               dest;
    } instr_t;

    typedef struct packed {
        logic               we;
        logic [FADDR_W-1:0] addr;
        logic [DATA_W-1:0]  wdata;
    } file_wr_t;

    typedef struct packed {
        logic            push;
        logic [PC_W-1:0] ret_addr;
    } stack_push_t;

    typedef struct packed {
        logic            load;
        logic [PC_W-1:0] target;
    } pc_load_t;

    // Ops whose result goes to the file or the accumulator by dest
    function automatic logic routes_by_dest(input op_t op);
        return (op == op_invert_file) || (op == op_minus_one) || (op == op_minus_one_skip);
    endfunction

endpackage

// [logic/core_op_alu.sv]
`timescale 1ns/1ps
module core_op_alu
    import core_op_pkg::*;
(
    // Operation
    input  wire op_t                op,
    input  wire logic [DATA_W-1:0]  file_val,
    // Result
    output      logic [DATA_W-1:0]  result,
    output      logic               result_zero
);

    // ------------------------------------------------------------
    // Data path
    // ------------------------------------------------------------
    always_comb begin
        unique case (op)
            op_invert_file:    result = ~file_val;
            op_minus_one,
            op_minus_one_skip: result = file_val - DEC_STEP;
            default:           result = ZERO_BYTE;
        endcase
        result_zero = (result == ZERO_BYTE);
    end

endmodule

// [logic/core_op_seq.sv]
`timescale 1ns/1ps
module core_op_seq
    import core_op_pkg::*;
(
    // Clock, reset, enable
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    // Starts
    input  wire logic start_call,
    input  wire logic start_skip,
    // State
    output      logic second_cycle,
    output      logic call_second
);

    typedef enum logic [1:0] {seq_idle, seq_call, seq_skip} seq_t;

    seq_t state_reg;
    seq_t state_next;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        if (ce) begin
            unique case (state_reg)
                seq_idle: begin
                    if (start_call)
                        state_next = seq_call;
                    else if (start_skip)
                        state_next = seq_skip;
                end
                seq_call: state_next = seq_idle;
                seq_skip: state_next = seq_idle;
                default:  state_next = seq_idle;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            state_reg <= seq_idle;
        else
            state_reg <= state_next;
    end

    assign second_cycle = (state_reg != seq_idle);
    assign call_second  = (state_reg == seq_call);

endmodule

// [logic/core_op_exec.sv]
`timescale 1ns/1ps
module core_op_exec
    import core_op_pkg::*;
(
    // Clock, reset, enable
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               ce,
    // Instruction issue
    input  wire logic               instr_valid,
    input  wire instr_t             instr,
    output      logic               instr_ready,
    // Core context
    input  wire logic [PC_W-1:0]    pc_cur,
    input  wire logic [PCH_W-1:0]   pc_high_latch,
    // File register bus
    output      logic [FADDR_W-1:0] file_raddr,
    input  wire logic [DATA_W-1:0]  file_rdata,
    output      file_wr_t           file_wr,
    // Flag events from the watchdog and sleep logic
    input  wire logic               wdog_timeout_evt,
    input  wire logic               sleep_evt,
    // Program flow
    output      stack_push_t        stack_push,
    output      pc_load_t           pc_load,
    output      logic               discard_fetch,
    // Watchdog service
    output      logic               wdog_clear,
    // Architectural state
    output      logic [DATA_W-1:0]  accum_reg,
    output      logic               result_nil_flag,
    output      logic               wdog_expired_flag_n,
    output      logic               sleep_entered_flag_n
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic              accept;
    logic              second_cycle;
    logic              call_second;
    logic [DATA_W-1:0] alu_result;
    logic              alu_zero;
    logic              skip_taken;

    logic [DATA_W-1:0] accum_next;
    logic              nil_reg;
    logic              nil_next;
    logic              wdt_n_reg;
    logic              wdt_n_next;
    logic              pd_n_reg;
    logic              pd_n_next;
    file_wr_t          file_wr_reg;
    file_wr_t          file_wr_next;
    stack_push_t       push_reg;
    stack_push_t       push_next;
    pc_load_t          pc_load_reg;
    pc_load_t          pc_load_next;
    logic              discard_reg;
    logic              discard_next;
    logic              kick_reg;
    logic              kick_next;

    // ------------------------------------------------------------
    // Issue handshake
    // ------------------------------------------------------------
    // single-cycle issue, except for a call or a taken skip
    // No new instruction during the second cycle of a call or skip; the
    // refused slot after a taken skip is the no-op run in place of the word
    assign instr_ready = !second_cycle;
    assign accept      = instr_valid && instr_ready && ce;
    // Read address follows the offered word so operand data is ready at accept
    assign file_raddr  = instr.faddr;

    assign skip_taken  = accept && (instr.op == op_minus_one_skip) && alu_zero;

    core_op_alu u_alu (
        .op          (instr.op),
        .file_val    (file_rdata),
        .result      (alu_result),
        .result_zero (alu_zero)
    );

    core_op_seq u_seq (
        .clk          (clk),
        .rst_n        (rst_n),
        .ce           (ce),
        .start_call   (accept && (instr.op == op_call_via_accum)),
        .start_skip   (skip_taken),
        .second_cycle (second_cycle),
        .call_second  (call_second)
    );

    // ------------------------------------------------------------
    // Execute
    // ------------------------------------------------------------
    // Pulses drop each enabled cycle; all state holds while ce is low
    always_comb begin
        accum_next   = accum_reg;
        nil_next     = nil_reg;
        wdt_n_next   = wdt_n_reg;
        pd_n_next    = pd_n_reg;
        file_wr_next = file_wr_reg;
        push_next    = push_reg;
        pc_load_next = pc_load_reg;
        discard_next = discard_reg;
        kick_next    = kick_reg;
        if (ce) begin
            file_wr_next.we = 1'b0;
            push_next.push  = 1'b0;
            pc_load_next.load = 1'b0;
            discard_next    = 1'b0;
            kick_next       = 1'b0;
            if (call_second) begin
                pc_load_next.load   = 1'b1;
                pc_load_next.target = {pc_high_latch, accum_reg};
            end
            if (accept) begin
                unique case (instr.op)
                    op_call_via_accum: begin
                        push_next.push     = 1'b1;
                        push_next.ret_addr = pc_cur + PC_STEP;
                    end
                    op_zero_file: begin
                        file_wr_next.we    = 1'b1;
                        file_wr_next.addr  = instr.faddr;
                        file_wr_next.wdata = ZERO_BYTE;
                        nil_next           = 1'b1;
                    end
                    op_zero_accum: begin
                        accum_next = ZERO_BYTE;
                        nil_next   = 1'b1;
                    end
                    op_kick: begin
                        kick_next  = 1'b1;
                        wdt_n_next = 1'b1;
                        pd_n_next  = 1'b1;
                    end
                    op_invert_file,
                    op_minus_one: begin
                        nil_next = alu_zero;
                    end
                    default: begin
                    end
                endcase
                if (routes_by_dest(instr.op)) begin
                    if (instr.dest == DEST_FILE) begin
                        file_wr_next.we    = 1'b1;
                        file_wr_next.addr  = instr.faddr;
                        file_wr_next.wdata = alu_result;
                    end else begin
                        accum_next = alu_result;
                    end
                end
                discard_next = skip_taken;
            end
            // Hardware events win over a kick in the same cycle
            if (wdog_timeout_evt)
                wdt_n_next = 1'b0;
            if (sleep_evt)
                pd_n_next = 1'b0;
        end
    end

    // State registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            accum_reg   <= ACCUM_RST;
            nil_reg     <= NIL_RST;
            wdt_n_reg   <= FLAG_N_RST;
            pd_n_reg    <= FLAG_N_RST;
            file_wr_reg <= '{we: 1'b0, addr: FADDR_RST, wdata: ZERO_BYTE};
            push_reg    <= '{push: 1'b0, ret_addr: PC_RST};
            pc_load_reg <= '{load: 1'b0, target: PC_RST};
            discard_reg <= 1'b0;
            kick_reg    <= 1'b0;
        end else begin
            accum_reg   <= accum_next;
            nil_reg     <= nil_next;
            wdt_n_reg   <= wdt_n_next;
            pd_n_reg    <= pd_n_next;
            file_wr_reg <= file_wr_next;
            push_reg    <= push_next;
            pc_load_reg <= pc_load_next;
            discard_reg <= discard_next;
            kick_reg    <= kick_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign file_wr              = file_wr_reg;
    assign stack_push           = push_reg;
    assign pc_load              = pc_load_reg;
    assign discard_fetch        = discard_reg;
    assign wdog_clear           = kick_reg;
    assign result_nil_flag      = nil_reg;
    assign wdog_expired_flag_n  = wdt_n_reg;
    assign sleep_entered_flag_n = pd_n_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_call_push;
        @(posedge clk) disable iff (!rst_n)
        accept && instr.op == op_call_via_accum |=>
            stack_push.push && stack_push.ret_addr == $past(pc_cur) + PC_STEP;
    endproperty
    a_call_push: assert property (p_call_push) else $error("call push wrong");

    property p_call_load;
        @(posedge clk) disable iff (!rst_n)
        accept && instr.op == op_call_via_accum ##1 ce |=>
            pc_load.load && !stack_push.push
            && pc_load.target == {$past(pc_high_latch), $past(accum_reg, 2)};
    endproperty
    a_call_load: assert property (p_call_load) else $error("call load wrong");

    property p_call_two;
        @(posedge clk) disable iff (!rst_n)
        accept && instr.op == op_call_via_accum |=>
            !instr_ready && $stable(result_nil_flag) && $stable(wdog_expired_flag_n)
            && $stable(sleep_entered_flag_n) ##1 (ce ? instr_ready : 1'b1);
    endproperty
    a_call_two: assert property (p_call_two) else $error("call cycles or flags");

    property p_zero_file;
        @(posedge clk) disable iff (!rst_n)
        accept && instr.op == op_zero_file |=>
            file_wr.we && file_wr.wdata == ZERO_BYTE
            && file_wr.addr == $past(instr.faddr) && result_nil_flag;
    endproperty
    a_zero_file: assert property (p_zero_file) else $error("file clear wrong");

    property p_zero_accum;
        @(posedge clk) disable iff (!rst_n)
        accept && instr.op == op_zero_accum |=>
            accum_reg == ZERO_BYTE && result_nil_flag && !file_wr.we;
    endproperty
    a_zero_accum: assert property (p_zero_accum) else $error("accum clear wrong");

    property p_kick;
        @(posedge clk) disable iff (!rst_n)
        accept && instr.op == op_kick && !wdog_timeout_evt && !sleep_evt |=>
            wdog_clear && wdog_expired_flag_n && sleep_entered_flag_n
            && $stable(result_nil_flag) && $stable(accum_reg);
    endproperty
    a_kick: assert property (p_kick) else $error("kick wrong");

    property p_invert;
        @(posedge clk) disable iff (!rst_n)
        accept && instr.op == op_invert_file && instr.dest == DEST_FILE |=>
            file_wr.we && file_wr.wdata == ~$past(file_rdata)
            && result_nil_flag == ($past(file_rdata) == 8'hFF);
    endproperty
    a_invert: assert property (p_invert) else $error("invert wrong");

    property p_minus_one;
        @(posedge clk) disable iff (!rst_n)
        accept && instr.op == op_minus_one && instr.dest == DEST_ACCUM |=>
            accum_reg == $past(file_rdata) - DEC_STEP && !file_wr.we
            && result_nil_flag == ($past(file_rdata) == 8'h01);
    endproperty
    a_minus_one: assert property (p_minus_one) else $error("decrement wrong");

    property p_skip;
        @(posedge clk) disable iff (!rst_n)
        accept && instr.op == op_minus_one_skip |=>
            discard_fetch == ($past(file_rdata) == 8'h01) && instr_ready == !discard_fetch
            && $stable(result_nil_flag);
    endproperty
    a_skip: assert property (p_skip) else $error("skip wrong");

    property p_single;
        @(posedge clk) disable iff (!rst_n)
        accept && instr.op != op_call_via_accum && !skip_taken |=> instr_ready;
    endproperty
    a_single: assert property (p_single) else $error("not single cycle");

endmodule

// [verif/tb_core_op_exec_call_clear_dec.sv]
`timescale 1ns/1ps
// Compare helper: counts every compare, reports mismatches at once
`define CHK(got, exp) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        n_fail++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
end

module tb_core_op_exec_call_clear_dec
    import core_op_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                clk;
    logic                rst_n;
    logic                ce;
    logic                instr_valid;
    logic                instr_ready;
    instr_t              instr;
    logic [PC_W-1:0]     pc_cur;
    logic [PCH_W-1:0]    pc_high_latch;
    logic [FADDR_W-1:0]  file_raddr;
    logic [DATA_W-1:0]   file_rdata;
    file_wr_t            file_wr;
    logic                wdog_timeout_evt;
    logic                sleep_evt;
    stack_push_t         stack_push;
    pc_load_t            pc_load;
    logic                discard_fetch;
    logic                wdog_clear;
    logic [DATA_W-1:0]   accum_reg;
    logic                result_nil_flag;
    logic                wdog_expired_flag_n;
    logic                sleep_entered_flag_n;
    logic [DATA_W-1:0]   mem [0:127];
    int                  n_fail;
    int                  cmp_count;

    core_op_exec dut (
        .clk                  (clk),
        .rst_n                (rst_n),
        .ce                   (ce),
        .instr_valid          (instr_valid),
        .instr                (instr),
        .instr_ready          (instr_ready),
        .pc_cur               (pc_cur),
        .pc_high_latch        (pc_high_latch),
        .file_raddr           (file_raddr),
        .file_rdata           (file_rdata),
        .file_wr              (file_wr),
        .wdog_timeout_evt     (wdog_timeout_evt),
        .sleep_evt            (sleep_evt),
        .stack_push           (stack_push),
        .pc_load              (pc_load),
        .discard_fetch        (discard_fetch),
        .wdog_clear           (wdog_clear),
        .accum_reg            (accum_reg),
        .result_nil_flag      (result_nil_flag),
        .wdog_expired_flag_n  (wdog_expired_flag_n),
        .sleep_entered_flag_n (sleep_entered_flag_n)
    );

    // ------------------------------------------------------------
    // File register model
    // ------------------------------------------------------------
    // Read is combinational, so a write shows from the next cycle on
    assign file_rdata = mem[file_raddr];
    always @(posedge clk) begin
        if (file_wr.we === 1'b1) begin
            mem[file_wr.addr] <= file_wr.wdata;
        end
    end

    // Clock, 20 ns period
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    // Inputs move 1 ns after the edge, never on it
    task automatic step();
        @(posedge clk);
        #1;
    endtask

    // Valid is left high so the next call can follow back to back
    task automatic issue(input op_t op, input logic [FADDR_W-1:0] fa, input logic d);
        instr_valid = 1'b1;
        instr       = '{op: op, faddr: fa, dest: d};
        step();
    endtask

    task automatic idle();
        instr_valid = 1'b0;
        step();
    endtask

    task automatic end_sim();
        $display("compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Watchdog: the tests need well under 100 cycles
    initial begin
        #(20 * 1000);
        n_fail++;
        end_sim();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        n_fail = 0; cmp_count = 0;
        rst_n = 1'b0; ce = 1'b1; instr_valid = 1'b0;
        instr = '{op: op_idle, faddr: 7'h00, dest: 1'b0};
        pc_cur = 15'h1234; pc_high_latch = 7'h55;
        wdog_timeout_evt = 1'b0; sleep_evt = 1'b0;
        for (int i = 0; i < 128; i++) mem[i] = 8'h00;
        mem[127] = 8'hA5; mem[16] = 8'hFF; mem[17] = 8'h0F; mem[18] = 8'h5A;
        mem[32] = 8'h01; mem[48] = 8'h01; mem[49] = 8'h05; mem[64] = 8'hC3;
        step(); step();
        rst_n = 1'b1;
        step();
        `CHK({accum_reg, result_nil_flag, wdog_expired_flag_n, sleep_entered_flag_n}, 11'h003)
        `CHK({instr_ready, file_wr.we, stack_push.push, pc_load.load}, 4'h8)
        $display("test reset done");

        // Zero, complement and decrement with both destinations
        issue(op_zero_file, 7'h7F, DEST_FILE);
        `CHK({file_wr.we, file_wr.addr, file_wr.wdata}, 16'hFF00)
        `CHK(result_nil_flag, 1'b1)
        issue(op_invert_file, 7'h10, DEST_ACCUM);
        `CHK(mem[127], 8'h00)
        `CHK({accum_reg, result_nil_flag, file_wr.we}, 10'h002)
        issue(op_invert_file, 7'h11, DEST_FILE);
        `CHK({file_wr.we, file_wr.addr, file_wr.wdata}, 16'h91F0)
        `CHK({accum_reg, result_nil_flag}, 9'h000)
        issue(op_invert_file, 7'h12, DEST_ACCUM);
        `CHK({accum_reg, result_nil_flag, file_wr.we}, 10'h294)
        issue(op_zero_accum, 7'h00, DEST_ACCUM);
        `CHK({accum_reg, result_nil_flag, file_wr.we}, 10'h002)
        issue(op_minus_one, 7'h20, DEST_FILE);
        `CHK({file_wr.we, file_wr.addr, file_wr.wdata}, 16'hA000)
        `CHK(result_nil_flag, 1'b1)
        issue(op_minus_one, 7'h21, DEST_ACCUM);
        `CHK({accum_reg, result_nil_flag, instr_ready}, 10'h3FD)
        $display("test zero_invert_decrement done");

        // Skip: nonzero continues, zero discards and refuses one cycle
        issue(op_minus_one_skip, 7'h31, DEST_FILE);
        `CHK({file_wr.we, file_wr.addr, file_wr.wdata}, 16'hB104)
        `CHK({discard_fetch, instr_ready, result_nil_flag}, 3'b010)
        issue(op_minus_one_skip, 7'h30, DEST_ACCUM);
        `CHK({accum_reg, file_wr.we}, 9'h000)
        `CHK({discard_fetch, instr_ready, result_nil_flag}, 3'b100)
        issue(op_zero_accum, 7'h00, DEST_ACCUM);
        `CHK({discard_fetch, instr_ready, result_nil_flag}, 3'b010)
        idle();
        `CHK(result_nil_flag, 1'b0)
        $display("test skip done");

        // Call through the accumulator
        issue(op_invert_file, 7'h40, DEST_ACCUM);
        `CHK(accum_reg, 8'h3C)
        issue(op_call_via_accum, 7'h00, DEST_ACCUM);
        `CHK({stack_push.push, stack_push.ret_addr}, {1'b1, 15'h1235})
        `CHK({pc_load.load, instr_ready}, 2'b00)
        idle();
        `CHK({pc_load.load, pc_load.target}, {1'b1, 7'h55, 8'h3C})
        `CHK({stack_push.push, instr_ready}, 2'b01)
        `CHK({result_nil_flag, wdog_expired_flag_n, sleep_entered_flag_n}, 3'b011)
        $display("test call done");

        // Watchdog service against flag events
        sleep_evt = 1'b1; wdog_timeout_evt = 1'b1;
        step();
        sleep_evt = 1'b0; wdog_timeout_evt = 1'b0;
        `CHK({wdog_expired_flag_n, sleep_entered_flag_n}, 2'b00)
        issue(op_kick, 7'h00, DEST_ACCUM);
        `CHK(wdog_clear, 1'b1)
        `CHK({wdog_expired_flag_n, sleep_entered_flag_n}, 2'b11)
        `CHK({accum_reg, result_nil_flag}, 9'h078)
        wdog_timeout_evt = 1'b1;
        issue(op_kick, 7'h00, DEST_ACCUM);
        wdog_timeout_evt = 1'b0;
        `CHK({wdog_clear, wdog_expired_flag_n, sleep_entered_flag_n}, 3'b101)
        idle();
        `CHK(wdog_clear, 1'b0)
        $display("test kick done");

        // Clock enable low holds an offered instruction back
        ce = 1'b0;
        issue(op_zero_accum, 7'h00, DEST_ACCUM);
        `CHK(accum_reg, 8'h3C)
        ce = 1'b1;
        step();
        `CHK({accum_reg, result_nil_flag}, 9'h001)
        idle();
        $display("test enable done");
        end_sim();
    end

endmodule
